// ==== ngpio_top.sv ====
// How it works
// - data nibbles and direction nibbles at fixed slots
// - direction 1 drives, 0 inputs; resets clear
// - alarm select drives alarm on A1, A2
// - segment selects turn C, D into segments
// - data writes never alter driven segment levels
// - input-only D2, D3 never become segments
// - global pull enable gates every pull-up
// - data bit zero turns its pull-up off
// - combined pull control applies to input pins
// - single supply also kills pull on outputs
// - ports B and C raise the port interrupt
// - resets clear load and alarm; all but a single-supply pad reset set blank
// - unimplemented bits read back as zero
// - any low input pin of port B or C sets port flag
// - segment port C excluded from interrupt sources
`include "ngpio_map.svh"
`timescale 1ns/1ps
`default_nettype none
module ngpio_top
    import ngpio_pkg::*;
#(
    parameter bit SINGLE_SUPPLY = 1'b0,
    parameter bit PD_HI_INPUT_ONLY = 1'b0,
    parameter int PINS = 16
)(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // other resets
    input wire logic pad_reset_n,
    input wire logic wdt_reset,
    // alternate function sources
    input wire logic alarm_out,
    input wire logic [3:0] seg_c,
    input wire logic [3:0] seg_d,
    // pads, index is port * 4 + bit
    input wire logic [15:0] pad_in,
    output logic [15:0] pad_out,
    output logic [15:0] pad_oe,
    output logic [15:0] pull_en,
    // status
    output logic display_blank,
    output logic heavy_load_select,
    output logic irq
);
    if (PINS != NGPIO_PINS) begin : g_bad_pins
        $error("ngpio_top: only four 4-bit ports are supported");
    end

    ngpio_state_t q_reg;
    ngpio_state_t q_next;
    ngpio_reg_req_t req;
    logic [3:0] rd_data;
    logic [NGPIO_SYNC_W-1:0] level;
    logic [15:0] pins;
    logic pad_rst;
    logic port_low;
    logic [3:0] c_low;
    logic [15:0] drv_out;
    logic [15:0] drv_oe;

    ngpio_ahb u_ahb (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .req(req),
        .rd_data(rd_data)
    );

    ngpio_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .raw({pad_reset_n, pad_in}),
        .level(level)
    );

    assign pins = level[15:0];
    assign pad_rst = !level[16];

    // input pins show the pad, output pins the latch
    function automatic logic [3:0] port_read(input logic [3:0] dat, input logic [3:0] dr,
            input logic [3:0] pin);
        port_read = (dat & dr) | (pin & ~dr);
    endfunction

    // pull-up of one nibble; pins driven by the block never pull
    function automatic logic [3:0] port_pull(input logic gp, input logic [3:0] dat,
            input logic [3:0] dr, input logic [3:0] oe);
        logic [3:0] p;
        p = {4{gp}} & dat & ~oe;
        if (SINGLE_SUPPLY) begin
            p = p & ~dr;
        end
        port_pull = p;
    endfunction

    // read mux; everything outside the implemented bits reads zero
    always_comb begin
        rd_data = 4'h0;
        unique case (req.idx)
            `NGPIO_IDX_PORT_A_DATA: rd_data = port_read(q_reg.data[0], q_reg.dir[0], pins[3:0]);
            `NGPIO_IDX_PORT_B_DATA: rd_data = port_read(q_reg.data[1], q_reg.dir[1], pins[7:4]);
            `NGPIO_IDX_PORT_C_DATA: rd_data = port_read(q_reg.data[2], q_reg.dir[2], pins[11:8]);
            `NGPIO_IDX_PORT_D_DATA: rd_data = port_read(q_reg.data[3], q_reg.dir[3],
                pins[15:12]);
            `NGPIO_IDX_ALARM_DISPLAY_LOAD: begin
                rd_data[`NGPIO_BIT_ALARM_SEL] = q_reg.alarm_sel;
                rd_data[`NGPIO_BIT_HEAVY_LOAD] = q_reg.heavy;
                rd_data[`NGPIO_BIT_DISPLAY_BLANK] = q_reg.blank;
            end
            `NGPIO_IDX_PULLUP_SEGMENT: begin
                rd_data[`NGPIO_BIT_PORTC_SEG] = q_reg.pc_seg;
                rd_data[`NGPIO_BIT_PORTD_SEG] = q_reg.pd_seg;
                rd_data[`NGPIO_BIT_GLOBAL_PULL] = q_reg.gpull;
            end
            `NGPIO_IDX_PORT_A_DIR: rd_data = q_reg.dir[0];
            `NGPIO_IDX_PORT_B_DIR: rd_data = q_reg.dir[1];
            `NGPIO_IDX_PORT_C_DIR: rd_data = q_reg.dir[2];
            `NGPIO_IDX_PORT_D_DIR: rd_data = q_reg.dir[3];
            `NGPIO_IDX_IRQ_STATUS: rd_data = q_reg.irq_stat;
            `NGPIO_IDX_IRQ_MASK: rd_data = q_reg.irq_mask;
            default: rd_data = 4'h0;
        endcase
    end

    // pad drive, alternate functions override normal port operation
    always_comb begin
        drv_out = {q_reg.data[3], q_reg.data[2], q_reg.data[1], q_reg.data[0]};
        drv_oe = {q_reg.dir[3], q_reg.dir[2], q_reg.dir[1], q_reg.dir[0]};
        if (q_reg.alarm_sel) begin
            drv_out[2:1] = {2{alarm_out}};
            drv_oe[2:1] = 2'h3;
        end
        // segment levels come only from the display driver, so data writes cannot reach them
        if (q_reg.pc_seg) begin
            drv_out[11:8] = seg_c;
            drv_oe[11:8] = 4'hf;
        end
        if (q_reg.pd_seg) begin
            drv_out[15:12] = seg_d;
            drv_oe[15:12] = 4'hf;
        end
        if (PD_HI_INPUT_ONLY) begin
            drv_out[15:14] = 2'h0;
            drv_oe[15:14] = 2'h0;
        end
    end

    // port interrupt sources: inputs of B always, of C only outside segment mode
    always_comb begin
        c_low = ~pins[11:8] & ~q_reg.dir[2];
        if (q_reg.pc_seg) begin
            c_low = 4'h0;
        end
        port_low = |(~pins[7:4] & ~q_reg.dir[1]) || |c_low;
    end

    always_comb begin
        q_next = q_reg;
        if (wdt_reset || pad_rst) begin
            q_next.data = '0;
            q_next.dir = '0;
            q_next.alarm_sel = 1'b0;
            q_next.heavy = 1'b0;
            q_next.pc_seg = 1'b0;
            q_next.pd_seg = 1'b0;
            q_next.gpull = 1'b0;
            q_next.irq_stat = `NGPIO_RST_IRQ;
            q_next.irq_mask = `NGPIO_RST_IRQ;
            // on a pad reset with single supply the blank bit is kept
            if (wdt_reset || !SINGLE_SUPPLY) begin
                q_next.blank = 1'b1;
            end
        end else begin
            if (req.wr) begin
                unique case (req.idx)
                    `NGPIO_IDX_PORT_A_DATA: q_next.data[0] = req.wdata;
                    `NGPIO_IDX_PORT_B_DATA: q_next.data[1] = req.wdata;
                    `NGPIO_IDX_PORT_C_DATA: q_next.data[2] = req.wdata;
                    `NGPIO_IDX_PORT_D_DATA: q_next.data[3] = req.wdata;
                    `NGPIO_IDX_ALARM_DISPLAY_LOAD: begin
                        q_next.alarm_sel = req.wdata[`NGPIO_BIT_ALARM_SEL];
                        q_next.heavy = req.wdata[`NGPIO_BIT_HEAVY_LOAD];
                        q_next.blank = req.wdata[`NGPIO_BIT_DISPLAY_BLANK];
                    end
                    `NGPIO_IDX_PULLUP_SEGMENT: begin
                        q_next.pc_seg = req.wdata[`NGPIO_BIT_PORTC_SEG];
                        q_next.pd_seg = req.wdata[`NGPIO_BIT_PORTD_SEG];
                        q_next.gpull = req.wdata[`NGPIO_BIT_GLOBAL_PULL];
                    end
                    `NGPIO_IDX_PORT_A_DIR: q_next.dir[0] = req.wdata;
                    `NGPIO_IDX_PORT_B_DIR: q_next.dir[1] = req.wdata;
                    `NGPIO_IDX_PORT_C_DIR: q_next.dir[2] = req.wdata;
                    `NGPIO_IDX_PORT_D_DIR: q_next.dir[3] = req.wdata;
                    `NGPIO_IDX_IRQ_STATUS: q_next.irq_stat = q_reg.irq_stat & ~req.wdata;
                    `NGPIO_IDX_IRQ_MASK: q_next.irq_mask = req.wdata & 4'h1;
                    default: q_next = q_next;
                endcase
            end
            // a low level present while software clears the flag keeps it set
            if (port_low) begin
                q_next.irq_stat[`NGPIO_BIT_IRQ_PORT] = 1'b1;
            end
        end
        q_next.pad_out = drv_out;
        q_next.pad_oe = drv_oe;
        q_next.pull_en = {port_pull(q_reg.gpull, q_reg.data[3], q_reg.dir[3], drv_oe[15:12]),
            port_pull(q_reg.gpull, q_reg.data[2], q_reg.dir[2], drv_oe[11:8]),
            port_pull(q_reg.gpull, q_reg.data[1], q_reg.dir[1], drv_oe[7:4]),
            port_pull(q_reg.gpull, q_reg.data[0], q_reg.dir[0], drv_oe[3:0])};
        q_next.irq = |(q_reg.irq_stat & q_reg.irq_mask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_reg <= '{data: '0, dir: '0, alarm_sel: 1'b0, heavy: 1'b0, blank: 1'b1,
                pc_seg: 1'b0, pd_seg: 1'b0, gpull: 1'b0, irq_stat: `NGPIO_RST_IRQ,
                irq_mask: `NGPIO_RST_IRQ, pad_out: 16'h0000, pad_oe: 16'h0000,
                pull_en: 16'h0000, irq: 1'b0};
        end else begin
            q_reg <= q_next;
        end
    end

    assign pad_out = q_reg.pad_out;
    assign pad_oe = q_reg.pad_oe;
    assign pull_en = q_reg.pull_en;
    assign display_blank = q_reg.blank;
    assign heavy_load_select = q_reg.heavy;
    assign irq = q_reg.irq;
endmodule
`default_nettype wire

// ==== ngpio_map.svh ====
`ifndef NGPIO_MAP_SVH
`define NGPIO_MAP_SVH

// register word indexes; byte address is four times the index
`define NGPIO_IDX_PORT_A_DATA 6'h08
`define NGPIO_IDX_PORT_B_DATA 6'h09
`define NGPIO_IDX_PORT_C_DATA 6'h0a
`define NGPIO_IDX_PORT_D_DATA 6'h0b
`define NGPIO_IDX_ALARM_DISPLAY_LOAD 6'h13
`define NGPIO_IDX_PULLUP_SEGMENT 6'h15
`define NGPIO_IDX_PORT_A_DIR 6'h1b
`define NGPIO_IDX_PORT_B_DIR 6'h1c
`define NGPIO_IDX_PORT_C_DIR 6'h1d
`define NGPIO_IDX_PORT_D_DIR 6'h1e
`define NGPIO_IDX_IRQ_STATUS 6'h20
`define NGPIO_IDX_IRQ_MASK 6'h21

// alarm_display_load_control fields
`define NGPIO_BIT_ALARM_SEL 0
`define NGPIO_BIT_HEAVY_LOAD 1
`define NGPIO_BIT_DISPLAY_BLANK 2

// pullup_segment_control fields
`define NGPIO_BIT_PORTC_SEG 1
`define NGPIO_BIT_PORTD_SEG 2
`define NGPIO_BIT_GLOBAL_PULL 3

// irq status / mask fields
`define NGPIO_BIT_IRQ_PORT 0

// reset values
`define NGPIO_RST_NIBBLE 4'h0
`define NGPIO_RST_ALARM_DISPLAY_LOAD 4'h4
`define NGPIO_RST_PULLUP_SEGMENT 4'h0
`define NGPIO_RST_IRQ 4'h0

`endif

// ==== ngpio_pkg.sv ====
package ngpio_pkg;

    localparam int NGPIO_PINS = 16;
    localparam int NGPIO_SYNC_W = NGPIO_PINS + 1;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] idx;
        logic [3:0] wdata;
    } ngpio_reg_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic bad;
        logic [5:0] idx;
        logic hreadyout;
        logic [31:0] hrdata;
    } ngpio_ahb_state_t;

    typedef struct packed {
        logic [NGPIO_SYNC_W-1:0] s1;
        logic [NGPIO_SYNC_W-1:0] s2;
        logic [NGPIO_SYNC_W-1:0] s3;
        logic [NGPIO_SYNC_W-1:0] level;
    } ngpio_sync_state_t;

    typedef struct packed {
        logic [3:0][3:0] data;
        logic [3:0][3:0] dir;
        logic alarm_sel;
        logic heavy;
        logic blank;
        logic pc_seg;
        logic pd_seg;
        logic gpull;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic [15:0] pad_out;
        logic [15:0] pad_oe;
        logic [15:0] pull_en;
        logic irq;
    } ngpio_state_t;

endpackage

// ==== ngpio_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module ngpio_sync
    import ngpio_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // raw and settled levels
    input wire logic [NGPIO_SYNC_W-1:0] raw,
    output logic [NGPIO_SYNC_W-1:0] level
);
    ngpio_sync_state_t q_reg;
    ngpio_sync_state_t q_next;

    // s1 is read only by s2; a level is taken once s2 and s3 agree
    always_comb begin
        q_next = q_reg;
        q_next.s1 = raw;
        q_next.s2 = q_reg.s1;
        q_next.s3 = q_reg.s2;
        for (int i = 0; i < NGPIO_SYNC_W; i++) begin
            if (q_reg.s2[i] == q_reg.s3[i]) begin
                q_next.level[i] = q_reg.s3[i];
            end
        end
    end

    // idle pins read high: pads float up and pad reset is inactive
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_reg <= '1;
        end else begin
            q_reg <= q_next;
        end
    end

    assign level = q_reg.level;
endmodule
`default_nettype wire

// ==== ngpio_ahb.sv ====
`timescale 1ns/1ps
`default_nettype none
module ngpio_ahb
    import ngpio_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // register side
    output ngpio_reg_req_t req,
    input wire logic [3:0] rd_data
);
    ngpio_ahb_state_t q_reg;
    ngpio_ahb_state_t q_next;
    logic accept;

    // reads take one wait state so a read right after a write sees the new value
    always_comb begin
        q_next = q_reg;
        accept = hsel && htrans[1] && hready;
        req = '0;
        req.idx = q_reg.idx;
        req.wdata = hwdata[3:0];
        req.wr = q_reg.valid && q_reg.write && !q_reg.bad;
        req.rd = q_reg.valid && !q_reg.write;
        if (q_reg.valid && !q_reg.write) begin
            q_next.hrdata = q_reg.bad ? 32'h0000_0000 : {28'h000_0000, rd_data};
            q_next.hreadyout = 1'b1;
        end
        if (q_reg.valid) begin
            q_next.valid = 1'b0;
        end
        if (accept) begin
            q_next.valid = 1'b1;
            q_next.write = hwrite;
            q_next.idx = haddr[7:2];
            q_next.bad = (haddr[1:0] != 2'h0) || (haddr[31:8] != 24'h00_0000)
                || (hsize != 3'h2);
            q_next.hreadyout = hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_reg <= '{valid: 1'b0, write: 1'b0, bad: 1'b0, idx: 6'h00,
                hreadyout: 1'b1, hrdata: 32'h0000_0000};
        end else begin
            q_reg <= q_next;
        end
    end

    assign hreadyout = q_reg.hreadyout;
    assign hrdata = q_reg.hrdata;
    assign hresp = 1'b0;
endmodule
`default_nettype wire

// ==== ngpio_pad_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ngpio_pad_model (
    // clock
    input wire logic hclk,
    // device side
    input wire logic [15:0] pad_out,
    input wire logic [15:0] pad_oe,
    input wire logic [15:0] pull_en,
    // board side
    input wire logic [15:0] ext_drv,
    input wire logic [15:0] ext_val,
    output logic [15:0] pad_in
);
    // undriven pads with no pull-up toggle every clock, so the synchroniser never settles and a floating input holds its last level
    logic [15:0] flt = 16'h0000;
    always_ff @(posedge hclk) begin
        flt <= ~flt;
    end
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            pad_in[i] = pad_oe[i] ? pad_out[i] : ext_drv[i] ? ext_val[i] : pull_en[i] | flt[i];
        end
    end
endmodule
`default_nettype wire

// ==== ngpio_top_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module ngpio_top_monitor #(
    parameter bit SINGLE_SUPPLY = 1'b0,
    parameter bit PD_HI_INPUT_ONLY = 1'b0
)(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    // resets and pads
    input wire logic pad_reset_n,
    input wire logic wdt_reset,
    input wire logic [15:0] pad_oe,
    input wire logic [15:0] pull_en,
    input wire logic display_blank,
    input wire logic heavy_load_select
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    wire logic go = hsel && htrans[1] && hready;
    a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
    a_read_wait: assert property (go && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_fast: assert property (go && hwrite |=> hreadyout) else $error("write stalled");
    a_upper_zero: assert property (hrdata[31:4] == 28'h0)
        else $error("upper read bits not zero");
    a_pull_input: assert property ((pad_oe & pull_en) == 16'h0)
        else $error("pull-up on driven pad");
    a_blank_start: assert property (
        $past(hresetn) == 1'b0 |-> display_blank && !heavy_load_select)
        else $error("reset state of display bits wrong");
    a_wdt_clear: assert property (
        wdt_reset ##1 wdt_reset |=> display_blank && pad_oe == 16'h0)
        else $error("watchdog reset did not act");
    a_pad_reset: assert property (
        !pad_reset_n [*8] |-> pad_oe == 16'h0 && (display_blank || SINGLE_SUPPLY))
        else $error("pad reset did not act");
    a_input_only: assert property (PD_HI_INPUT_ONLY |-> pad_oe[15:14] == 2'b00)
        else $error("input-only pad driven");
    cover property (go && !hwrite);
    cover property (go && hwrite);
    cover property (wdt_reset ##1 wdt_reset);
    cover property (!pad_reset_n [*8]);
endmodule
bind ngpio_top ngpio_top_monitor #(
    .SINGLE_SUPPLY(SINGLE_SUPPLY),
    .PD_HI_INPUT_ONLY(PD_HI_INPUT_ONLY)
) mon_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .pad_reset_n(pad_reset_n), .wdt_reset(wdt_reset), .pad_oe(pad_oe), .pull_en(pull_en),
    .display_blank(display_blank), .heavy_load_select(heavy_load_select)
);
`default_nettype wire

// ==== ngpio_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ngpio_map.svh"
module ngpio_top_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic pad_reset_n = 1'b1;
    logic wdt_reset = 1'b0;
    logic alarm_out = 1'b0;
    logic [3:0] seg_c = 4'h0;
    logic [3:0] seg_d = 4'h0;
    // board drives every pad so no input floats into a read or an interrupt check
    logic [15:0] ext_drv = 16'hffff;
    logic [15:0] ext_val = 16'h0ff0;
    wire hreadyout, hresp, display_blank, heavy_load_select, irq;
    wire [31:0] hrdata;
    wire [15:0] pad_in, pad_out, pad_oe, pull_en;
    int failures = 0;
    int n_tests = 0;
    ngpio_top #(.SINGLE_SUPPLY(1'b0), .PD_HI_INPUT_ONLY(1'b1), .PINS(16)) ngpio_top_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pad_reset_n(pad_reset_n),
        .wdt_reset(wdt_reset), .alarm_out(alarm_out), .seg_c(seg_c), .seg_d(seg_d),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pull_en(pull_en),
        .display_blank(display_blank), .heavy_load_select(heavy_load_select), .irq(irq)
    );
    ngpio_pad_model ngpio_pad_model_i (
        .hclk(hclk), .pad_out(pad_out), .pad_oe(pad_oe), .pull_en(pull_en),
        .ext_drv(ext_drv), .ext_val(ext_val), .pad_in(pad_in)
    );
    initial begin
        forever #12.5 hclk = ~hclk;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // single slave, so hreadyout doubles as hready and every wait is on it
    task automatic xfer(input logic w, input logic [5:0] i, input logic [3:0] wd,
            output logic [31:0] rd);
        haddr <= {24'h0, i, 2'b00};
        hwrite <= w;
        htrans <= 2'b10;
        hsel <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {28'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [5:0] i, input logic [3:0] d);
        logic [31:0] r;
        xfer(1'b1, i, d, r);
    endtask
    task automatic rchk(input logic [5:0] i, input logic [3:0] exp);
        logic [31:0] r;
        xfer(1'b0, i, 4'h0, r);
        chk(r, {28'h0, exp});
    endtask
    task automatic t_reset();
        chk({display_blank, heavy_load_select, irq, pad_oe}, 19'h40000);
        // pad levels need four clocks through the synchroniser after reset
        wt(4);
        rchk(`NGPIO_IDX_PORT_A_DATA, 4'h0);
        rchk(`NGPIO_IDX_ALARM_DISPLAY_LOAD, 4'h4);
        rchk(`NGPIO_IDX_PULLUP_SEGMENT, 4'h0);
        rchk(`NGPIO_IDX_PORT_D_DIR, 4'h0);
        rchk(6'h0c, 4'h0);
        wr(`NGPIO_IDX_IRQ_MASK, 4'hf);
        rchk(`NGPIO_IDX_IRQ_MASK, 4'h1);
    endtask
    task automatic t_ports();
        wr(`NGPIO_IDX_PORT_A_DIR, 4'hf);
        wr(`NGPIO_IDX_PORT_A_DATA, 4'h5);
        wr(`NGPIO_IDX_PULLUP_SEGMENT, 4'h8);
        wr(`NGPIO_IDX_PORT_B_DATA, 4'hf);
        wt(3);
        chk({pad_oe[3:0], pad_out[3:0]}, 8'hf5);
        chk(pull_en, 16'h00f0);
        wr(`NGPIO_IDX_PORT_B_DATA, 4'h3);
        wt(3);
        chk(pull_en, 16'h0030);
        wr(`NGPIO_IDX_PULLUP_SEGMENT, 4'h0);
        wt(3);
        chk(pull_en, 16'h0000);
        rchk(`NGPIO_IDX_PORT_A_DATA, 4'h5);
        ext_val <= 16'h0fa0;
        wt(6);
        rchk(`NGPIO_IDX_PORT_B_DATA, 4'ha);
    endtask
    task automatic t_alarm();
        wr(`NGPIO_IDX_ALARM_DISPLAY_LOAD, 4'h5);
        alarm_out <= 1'b1;
        wt(3);
        chk({pad_oe[2:1], pad_out[2:1]}, 4'hf);
        alarm_out <= 1'b0;
        wt(3);
        chk(pad_out[2:1], 2'b00);
        wr(`NGPIO_IDX_ALARM_DISPLAY_LOAD, 4'h2);
        wt(3);
        chk({display_blank, heavy_load_select}, 2'b01);
    endtask
    task automatic t_segment();
        seg_c <= 4'h9;
        seg_d <= 4'h6;
        wr(`NGPIO_IDX_PULLUP_SEGMENT, 4'h6);
        wr(`NGPIO_IDX_PORT_C_DATA, 4'h0);
        wt(3);
        chk({pad_oe[11:8], pad_out[11:8]}, 8'hf9);
        chk({pad_oe[15:12], pad_out[13:12]}, 6'h0e);
    endtask
    task automatic t_irq();
        ext_val <= 16'h0ff0;
        seg_c <= 4'h0;
        wr(`NGPIO_IDX_PULLUP_SEGMENT, 4'h2);
        wt(8);
        wr(`NGPIO_IDX_IRQ_STATUS, 4'h1);
        wt(3);
        chk(irq, 1'b0);
        ext_val[4] <= 1'b0;
        wt(8);
        chk(irq, 1'b1);
        ext_val[4] <= 1'b1;
        wr(`NGPIO_IDX_PULLUP_SEGMENT, 4'h0);
        wt(8);
        wr(`NGPIO_IDX_IRQ_STATUS, 4'h1);
        wr(`NGPIO_IDX_IRQ_MASK, 4'h0);
        wt(3);
        chk(irq, 1'b0);
        ext_val[8] <= 1'b0;
        wt(8);
        rchk(`NGPIO_IDX_IRQ_STATUS, 4'h1);
        chk(irq, 1'b0);
        ext_val[8] <= 1'b1;
    endtask
    task automatic t_resets();
        wdt_reset <= 1'b1;
        wt(2);
        wdt_reset <= 1'b0;
        wt(2);
        chk({display_blank, heavy_load_select}, 2'b10);
        rchk(`NGPIO_IDX_PORT_A_DIR, 4'h0);
        wr(`NGPIO_IDX_ALARM_DISPLAY_LOAD, 4'h0);
        wr(`NGPIO_IDX_PORT_B_DIR, 4'hf);
        pad_reset_n <= 1'b0;
        wt(10);
        pad_reset_n <= 1'b1;
        wt(6);
        chk({display_blank, pad_oe}, 17'h10000);
        wr(`NGPIO_IDX_ALARM_DISPLAY_LOAD, 4'h0);
        hresetn <= 1'b0;
        wt(2);
        hresetn <= 1'b1;
        wt(1);
        rchk(`NGPIO_IDX_ALARM_DISPLAY_LOAD, 4'h4);
    endtask
    task automatic print_verdict();
        if (failures == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge hclk);
        failures++;
        print_verdict();
    end
    initial begin
        wt(12);
        hresetn <= 1'b1;
        wt(1);
        t_reset();
        t_ports();
        t_alarm();
        t_segment();
        t_irq();
        t_resets();
        print_verdict();
    end
endmodule
`default_nettype wire
